// ==== rtl/rsc_pkg.sv ====
/*
  Constants for the redundancy switch controller: timing figures and the
  cycle counts derived from them at the reference clock rate.
  Assumes a single 40 MHz reference clock.
*/
package rsc_pkg;
  // --------------------------------------------------------------------
  // Clock
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  // --------------------------------------------------------------------
  // Times in their own units
  // --------------------------------------------------------------------
  localparam int unsigned TOGGLE_MIN_MS = 100;
  localparam int unsigned CMD_PULSE_MS = 350;
  localparam int unsigned BEAT_HALF_MS = 1000;
  localparam int unsigned DEBOUNCE_US = 10000;
  // --------------------------------------------------------------------
  // Derived cycle counts
  // --------------------------------------------------------------------
  localparam int unsigned TOGGLE_MIN_CYC = (CLK_HZ / 1000) * TOGGLE_MIN_MS;
  localparam int unsigned CMD_PULSE_CYC = (CLK_HZ / 1000) * CMD_PULSE_MS;
  localparam int unsigned BEAT_HALF_CYC = (CLK_HZ / 1000) * BEAT_HALF_MS;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned CNT_W = 32;
  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic RST_ONLINE_B = 1'b0;
endpackage : rsc_pkg

// ==== rtl/rsc_filt_if.sv ====
/*
  Interface carrying the synchronised, debounced input levels from the
  input filter to the controller core.
  Assumes both ends run on the same reference clock.
*/
interface rsc_filt_if;
  logic mode_open;
  logic toggle_low;
  logic fault_a;
  logic fault_b;
  logic pos_a;
  logic pos_b;
  modport src (output mode_open, toggle_low, fault_a, fault_b, pos_a, pos_b);
  modport dst (input mode_open, toggle_low, fault_a, fault_b, pos_a, pos_b);
endinterface : rsc_filt_if

// ==== rtl/rsc_filter.sv ====
/*
  Input conditioner: two-stage synchroniser then a stability debounce for
  each contact input, one generate entry per input.
  Assumes raw pins are asynchronous to the reference clock.
*/
module rsc_filter #(
  parameter int unsigned N = 6,
  parameter int unsigned DEB_CYC = rsc_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] raw_i,
  input wire logic [N-1:0] rst_val_i,
  output logic [N-1:0] level_o
);
  // ----------------------------------------------------------------------
  // Per-input synchroniser and debounce
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_in
      logic s1_reg;
      logic s2_reg;
      logic lvl_reg;
      logic off_idle;
      logic [rsc_pkg::CNT_W-1:0] cnt_reg;
      // Two flops; the first is read by the second only
      always_ff @(posedge clk_i)
      begin
        s1_reg <= raw_i[g];
        s2_reg <= s1_reg;
      end
      // Held relative to the idle value, so reset lands on the idle level
      assign off_idle = s2_reg ^ rst_val_i[g];
      // Level follows the input only after it stays put for DEB_CYC
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          lvl_reg <= 1'b0;
          cnt_reg <= '0;
        end
        else if (off_idle == lvl_reg)
          cnt_reg <= '0;
        else if (cnt_reg >= rsc_pkg::CNT_W'(DEB_CYC - 1))
        begin
          lvl_reg <= off_idle;
          cnt_reg <= '0;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
      assign level_o[g] = lvl_reg ^ rst_val_i[g];
    end
  endgenerate
endmodule : rsc_filter

// ==== rtl/rsc_core.sv ====
/*
  Redundancy switch controller for a 1:1 pair of transceiver units.
  Watches unit fault contacts and a toggle request, pulses the transfer
  switch position commands and drives the health heartbeat.
  Assumes contact inputs are open-collector levels: 1 = open, 0 = grounded,
  and the remote commands arrive as one-cycle pulses from a local parser.
*/
// Functional notes
// - Mode select pin open means automatic mode unless remote manual is set.
// - Mode select pin grounded forces manual mode over any remote setting.
// - With mode pin open, the last remote mode command picks the mode.
// - Automatic: online unit faulted commands both switches to other unit.
// - No automatic switchover while the offline unit is also faulted.
// - Automatic toggle swaps only when the offline unit is healthy.
// - Manual toggle swaps both switches whatever the faults, except during a command pulse.
// - Remote toggle command acts exactly like a valid toggle pulse.
// - Redundant configuration indication driven to both units.
// - Half-hertz heartbeat while healthy; stopped when a problem exists.
// - Control bus passed to both units; unit B select asserted.
// - One 350 ms position command pulse per switch per switchover.
// - Fault contact closed reads healthy, open reads faulted.
// - Position indicators read; position outputs active for online unit.
module rsc_core #(
  parameter int unsigned PULSE_CYC = rsc_pkg::CMD_PULSE_CYC,
  parameter int unsigned TOG_CYC = rsc_pkg::TOGGLE_MIN_CYC,
  parameter int unsigned BEAT_CYC = rsc_pkg::BEAT_HALF_CYC,
  parameter int unsigned DEB_CYC = rsc_pkg::DEBOUNCE_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic MODE_SEL_I,
  input wire logic TOGGLE_REQ_I,
  input wire logic FAULT_A_I,
  input wire logic FAULT_B_I,
  input wire logic TX_POS_A_IND_I,
  input wire logic TX_POS_B_IND_I,
  input wire logic RX_POS_A_IND_I,
  input wire logic RX_POS_B_IND_I,
  input wire logic REMOTE_MODE_SET_I,
  input wire logic REMOTE_MODE_MANUAL_I,
  input wire logic REMOTE_TOGGLE_I,
  input wire logic MC_RX_I,
  input wire logic MC_TX_A_I,
  input wire logic MC_TX_B_I,
  output logic MC_RX_A_O,
  output logic MC_RX_B_O,
  output logic MC_TX_O,
  output logic TX_CMD_A_O,
  output logic TX_CMD_B_O,
  output logic RX_CMD_A_O,
  output logic RX_CMD_B_O,
  output logic POSITION_A_N_O,
  output logic POSITION_B_N_O,
  output logic REDUNDANT_CFG_A_N_O,
  output logic REDUNDANT_CFG_B_N_O,
  output logic UNIT_B_SELECT_N_O,
  output logic HEALTH_HEARTBEAT_O,
  output logic MANUAL_MODE_O,
  output logic SWITCH_FAULT_O
);
  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  rsc_filt_if flt ();
  logic [5:0] lvl;
  logic [1:0] rx_ind_s1, rx_ind_s2;

  // Levels reset to idle: mode and toggle open, contacts closed, switch at A
  rsc_filter #(.N(6), .DEB_CYC(DEB_CYC)) u_filt (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .raw_i({MODE_SEL_I, TOGGLE_REQ_I, FAULT_A_I, FAULT_B_I,
            TX_POS_A_IND_I, TX_POS_B_IND_I}),
    .rst_val_i(6'h31),
    .level_o(lvl)
  );
  assign flt.mode_open = lvl[5];
  assign flt.toggle_low = ~lvl[4];
  assign flt.fault_a = lvl[3];
  assign flt.fault_b = lvl[2];
  assign flt.pos_a = ~lvl[1];
  assign flt.pos_b = ~lvl[0];

  // Rx switch indicators only feed the health check, so two flops suffice
  always_ff @(posedge REF_CLK_I)
  begin
    rx_ind_s1 <= {RX_POS_A_IND_I, RX_POS_B_IND_I};
    rx_ind_s2 <= rx_ind_s1;
  end

  // ----------------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------------
  logic remote_manual_reg;
  logic manual;

  // Remote setting is remembered even while the pin overrides it
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      remote_manual_reg <= 1'b0;
    else if (REMOTE_MODE_SET_I)
      remote_manual_reg <= REMOTE_MODE_MANUAL_I;
  end
  assign manual = !flt.mode_open || remote_manual_reg;

  // ----------------------------------------------------------------------
  // Toggle request qualification
  // ----------------------------------------------------------------------
  logic [rsc_pkg::CNT_W-1:0] low_cnt_reg;
  logic tog_seen_reg;
  logic tog_pulse;

  // One request per low period, once it has lasted the minimum width
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      low_cnt_reg <= '0;
      tog_seen_reg <= 1'b0;
    end
    else if (!flt.toggle_low)
    begin
      low_cnt_reg <= '0;
      tog_seen_reg <= 1'b0;
    end
    else if (!tog_seen_reg)
    begin
      if (low_cnt_reg >= rsc_pkg::CNT_W'(TOG_CYC - 1))
        tog_seen_reg <= 1'b1;
      else
        low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end
  assign tog_pulse = (flt.toggle_low && !tog_seen_reg &&
    low_cnt_reg >= rsc_pkg::CNT_W'(TOG_CYC - 1)) ||
    REMOTE_TOGGLE_I;

  // ----------------------------------------------------------------------
  // Switchover decision and command pulse
  // ----------------------------------------------------------------------
  logic online_b_reg;
  logic busy;
  logic off_fault;
  logic on_fault;
  logic do_swap;
  logic [rsc_pkg::CNT_W-1:0] pulse_cnt_reg;

  assign off_fault = online_b_reg ? flt.fault_a : flt.fault_b;
  assign on_fault = online_b_reg ? flt.fault_b : flt.fault_a;
  assign busy = pulse_cnt_reg != '0;
  assign do_swap = !busy && (
    (tog_pulse && (manual || !off_fault)) ||
    (!manual && on_fault && !off_fault));

  // Selected unit; follows the Tx switch indicators when idle and agreeing
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      online_b_reg <= rsc_pkg::RST_ONLINE_B;
    else if (do_swap)
      online_b_reg <= !online_b_reg;
    else if (!busy && (flt.pos_a ^ flt.pos_b))
      online_b_reg <= flt.pos_b;
  end

  // Pulse width counter, one pulse per switchover
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      pulse_cnt_reg <= '0;
    else if (do_swap)
      pulse_cnt_reg <= rsc_pkg::CNT_W'(PULSE_CYC);
    else if (busy)
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
  end

  // Both switches driven together toward the new unit
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      TX_CMD_A_O <= 1'b0;
      TX_CMD_B_O <= 1'b0;
      RX_CMD_A_O <= 1'b0;
      RX_CMD_B_O <= 1'b0;
    end
    else if (do_swap)
    begin
      TX_CMD_A_O <= online_b_reg;
      TX_CMD_B_O <= !online_b_reg;
      RX_CMD_A_O <= online_b_reg;
      RX_CMD_B_O <= !online_b_reg;
    end
    else if (pulse_cnt_reg == rsc_pkg::CNT_W'(1))
    begin
      TX_CMD_A_O <= 1'b0;
      TX_CMD_B_O <= 1'b0;
      RX_CMD_A_O <= 1'b0;
      RX_CMD_B_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Health heartbeat
  // ----------------------------------------------------------------------
  logic [rsc_pkg::CNT_W-1:0] beat_cnt_reg;
  logic sw_fault;

  // After the pulse settles both switches must agree with the selection;
  // the Rx indicators are still active low here
  assign sw_fault = !busy && (
    (flt.pos_a == flt.pos_b) || (rx_ind_s2[1] == rx_ind_s2[0]) ||
    (flt.pos_b != online_b_reg) || (rx_ind_s2[0] == online_b_reg));

  // Square wave stops low on a problem, so the units see it go away
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I || sw_fault)
    begin
      beat_cnt_reg <= '0;
      HEALTH_HEARTBEAT_O <= 1'b0;
    end
    else if (beat_cnt_reg >= rsc_pkg::CNT_W'(BEAT_CYC - 1))
    begin
      beat_cnt_reg <= '0;
      HEALTH_HEARTBEAT_O <= !HEALTH_HEARTBEAT_O;
    end
    else
      beat_cnt_reg <= beat_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Static indications and control bus pass-through
  // ----------------------------------------------------------------------
  // Registered pass-through adds one cycle, negligible at serial rates
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      MC_RX_A_O <= 1'b1;
      MC_RX_B_O <= 1'b1;
      MC_TX_O <= 1'b1;
      POSITION_A_N_O <= 1'b1;
      POSITION_B_N_O <= 1'b1;
      REDUNDANT_CFG_A_N_O <= 1'b1;
      REDUNDANT_CFG_B_N_O <= 1'b1;
      UNIT_B_SELECT_N_O <= 1'b1;
      MANUAL_MODE_O <= 1'b0;
      SWITCH_FAULT_O <= 1'b0;
    end
    else
    begin
      MC_RX_A_O <= MC_RX_I;
      MC_RX_B_O <= MC_RX_I;
      MC_TX_O <= MC_TX_A_I & MC_TX_B_I;
      POSITION_A_N_O <= online_b_reg;
      POSITION_B_N_O <= !online_b_reg;
      REDUNDANT_CFG_A_N_O <= 1'b0;
      REDUNDANT_CFG_B_N_O <= 1'b0;
      UNIT_B_SELECT_N_O <= 1'b0;
      MANUAL_MODE_O <= manual;
      SWITCH_FAULT_O <= sw_fault;
    end
  end
endmodule : rsc_core

// ==== sim/rsc_core_checker.sv ====
/*
  Port checker for rsc_core, bound to every instance of it.
  Assumes the bind hands on the shortened count parameters.
*/
module rsc_core_checker #(
  parameter int unsigned PULSE_CYC = 20,
  parameter int unsigned DEB_CYC = 4,
  parameter int unsigned BEAT_CYC = 16
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic MODE_SEL_I,
  input wire logic MC_RX_I,
  input wire logic MC_RX_A_O,
  input wire logic MC_RX_B_O,
  input wire logic TX_CMD_A_O,
  input wire logic TX_CMD_B_O,
  input wire logic RX_CMD_A_O,
  input wire logic RX_CMD_B_O,
  input wire logic POSITION_A_N_O,
  input wire logic POSITION_B_N_O,
  input wire logic REDUNDANT_CFG_A_N_O,
  input wire logic REDUNDANT_CFG_B_N_O,
  input wire logic UNIT_B_SELECT_N_O,
  input wire logic HEALTH_HEARTBEAT_O,
  input wire logic MANUAL_MODE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cmd;
  logic [31:0] hi_cnt;
  logic [31:0] gnd_cnt;
  logic [31:0] beat_cnt;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  // --------------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------------
  // Any Tx coil energised; Tx and Rx pairing is checked on its own
  assign cmd = TX_CMD_A_O | TX_CMD_B_O;
  // Pulse length, grounded-pin time and heartbeat high time
  always_ff @(posedge REF_CLK_I)
  begin
    hi_cnt <= (RST_I || !cmd) ? 32'h0 : hi_cnt + 32'h1;
    gnd_cnt <= (RST_I || MODE_SEL_I) ? 32'h0 : gnd_cnt + 32'h1;
    beat_cnt <= (RST_I || !HEALTH_HEARTBEAT_O) ? 32'h0 : beat_cnt + 32'h1;
  end
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  AST_TXRX_A: assert property (TX_CMD_A_O == RX_CMD_A_O)
    else $error("Tx and Rx position A commands differ");
  AST_TXRX_B: assert property (TX_CMD_B_O == RX_CMD_B_O)
    else $error("Tx and Rx position B commands differ");
  AST_ONE_SIDE: assert property (!(TX_CMD_A_O && TX_CMD_B_O))
    else $error("Both position commands high");
  AST_PULSE_LEN: assert property ($fell(cmd) |-> hi_cnt == PULSE_CYC)
    else $error("Command pulse length wrong");
  AST_NO_RETRIG: assert property (cmd |-> hi_cnt < PULSE_CYC)
    else $error("Command pulse stretched by a new request");
  AST_GO_B: assert property ($rose(TX_CMD_B_O) |-> ##[0:2]
    (!POSITION_B_N_O && POSITION_A_N_O))
    else $error("Unit B not shown online after switchover");
  AST_GO_A: assert property ($rose(TX_CMD_A_O) |-> ##[0:2]
    (!POSITION_A_N_O && POSITION_B_N_O))
    else $error("Unit A not shown online after switchover");
  AST_ONLINE_ONE: assert property (!$past(RST_I) |->
    POSITION_A_N_O != POSITION_B_N_O)
    else $error("Online indications not exclusive");
  AST_CFG_LOW: assert property (!$past(RST_I) |->
    !(REDUNDANT_CFG_A_N_O || REDUNDANT_CFG_B_N_O))
    else $error("Redundant configuration flag not driven");
  AST_BUS_PASS: assert property (!$past(RST_I) |-> !UNIT_B_SELECT_N_O &&
    MC_RX_A_O == $past(MC_RX_I) && MC_RX_B_O == $past(MC_RX_I))
    else $error("Control bus not passed to both units");
  AST_GND_MANUAL: assert property (gnd_cnt > DEB_CYC + 8 |-> MANUAL_MODE_O)
    else $error("Grounded mode pin did not force manual");
  AST_BEAT_HALF: assert property (beat_cnt <= BEAT_CYC)
    else $error("Heartbeat high phase too long");
  cover property ($rose(TX_CMD_B_O));
  cover property ($rose(TX_CMD_A_O));
  cover property ($rose(MANUAL_MODE_O));
endmodule : rsc_core_checker

bind rsc_core rsc_core_checker #(
  .PULSE_CYC(PULSE_CYC), .DEB_CYC(DEB_CYC), .BEAT_CYC(BEAT_CYC)
) rsc_core_checker_inst (
  .REF_CLK_I, .RST_I, .MODE_SEL_I, .MC_RX_I, .MC_RX_A_O, .MC_RX_B_O,
  .TX_CMD_A_O, .TX_CMD_B_O, .RX_CMD_A_O, .RX_CMD_B_O, .POSITION_A_N_O,
  .POSITION_B_N_O, .REDUNDANT_CFG_A_N_O, .REDUNDANT_CFG_B_N_O,
  .UNIT_B_SELECT_N_O, .HEALTH_HEARTBEAT_O, .MANUAL_MODE_O
);

// ==== sim/rsc_switch_model.sv ====
/*
  Transfer switch model: coil commands in, position indicators out.
  Assumes indicators are active low, shorted for the reached position.
*/
module rsc_switch_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_a_i,
  input wire logic cmd_b_i,
  input wire logic stuck_i,
  output logic ind_a_n_o,
  output logic ind_b_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic at_b_reg;
  // Rotor follows the energised coil; no travel time is modelled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      at_b_reg <= 1'b0;
    else if (stuck_i)
      at_b_reg <= at_b_reg;  // Jammed rotor ignores its coils
    else if (cmd_b_i)
      at_b_reg <= 1'b1;
    else if (cmd_a_i)
      at_b_reg <= 1'b0;
  end
  // Exactly one indicator is shorted at any time
  assign ind_a_n_o = at_b_reg;
  assign ind_b_n_o = !at_b_reg;
endmodule : rsc_switch_model

// ==== sim/rsc_core_bench.sv ====
/*
  Self-checking bench for rsc_core with two transfer switch models.
  Assumes the shortened counts below; inputs change at falling edges.
*/
module rsc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned BEAT = 16;
  logic clk = 1'b0, rst = 1'b1, mode_sel = 1'b1, tog_req = 1'b1;
  logic flt_a = 1'b0, flt_b = 1'b0, rm_set = 1'b0, rm_man = 1'b0;
  logic r_tog = 1'b0, mc_rx = 1'b1, mc_ta = 1'b1, mc_tb = 1'b1;
  logic rx_stuck = 1'b0;
  logic tx_ia, tx_ib, rx_ia, rx_ib, mc_ra, mc_rb, mc_tx, tx_ca, tx_cb;
  logic rx_ca, rx_cb, pos_a_n, pos_b_n, cfg_a_n, cfg_b_n, bsel_n;
  logic beat, manual, sw_flt;
  int fail_count = 0, checks = 0, cycles = 0;
  rsc_core #(.PULSE_CYC(20), .TOG_CYC(10), .BEAT_CYC(BEAT), .DEB_CYC(4))
  rsc_core_inst (.REF_CLK_I(clk), .RST_I(rst), .MODE_SEL_I(mode_sel),
    .TOGGLE_REQ_I(tog_req), .FAULT_A_I(flt_a), .FAULT_B_I(flt_b),
    .TX_POS_A_IND_I(tx_ia), .TX_POS_B_IND_I(tx_ib), .RX_POS_A_IND_I(rx_ia),
    .RX_POS_B_IND_I(rx_ib), .REMOTE_MODE_SET_I(rm_set),
    .REMOTE_MODE_MANUAL_I(rm_man), .REMOTE_TOGGLE_I(r_tog), .MC_RX_I(mc_rx),
    .MC_TX_A_I(mc_ta), .MC_TX_B_I(mc_tb), .MC_RX_A_O(mc_ra), .MC_RX_B_O(mc_rb),
    .MC_TX_O(mc_tx), .TX_CMD_A_O(tx_ca), .TX_CMD_B_O(tx_cb),
    .RX_CMD_A_O(rx_ca), .RX_CMD_B_O(rx_cb), .POSITION_A_N_O(pos_a_n),
    .POSITION_B_N_O(pos_b_n), .REDUNDANT_CFG_A_N_O(cfg_a_n),
    .REDUNDANT_CFG_B_N_O(cfg_b_n), .UNIT_B_SELECT_N_O(bsel_n),
    .HEALTH_HEARTBEAT_O(beat), .MANUAL_MODE_O(manual),
    .SWITCH_FAULT_O(sw_flt));
  rsc_switch_model tx_sw_inst (.clk_i(clk), .rst_i(rst), .cmd_a_i(tx_ca),
    .cmd_b_i(tx_cb), .stuck_i(1'b0), .ind_a_n_o(tx_ia), .ind_b_n_o(tx_ib));
  rsc_switch_model rx_sw_inst (.clk_i(clk), .rst_i(rst), .cmd_a_i(rx_ca),
    .cmd_b_i(rx_cb), .stuck_i(rx_stuck), .ind_a_n_o(rx_ia),
    .ind_b_n_o(rx_ib));
  // 40 MHz reference clock
  always #12.5 clk = ~clk;
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(string nm, logic seen, logic exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Remote commands come as one-cycle strobes from the parser
  task automatic rtoggle();
    r_tog = 1'b1;
    tick(1);
    r_tog = 1'b0;
  endtask : rtoggle
  task automatic rmode(logic m);
    rm_man = m;
    rm_set = 1'b1;
    tick(1);
    rm_set = 1'b0;
    tick(3);
  endtask : rmode
  // Long enough for debounce plus a full pulse, so the switch is at rest
  task automatic settle(logic b_on);
    tick(40);
    chk("pos_b_n", pos_b_n, !b_on);
    chk("pos_a_n", pos_a_n, b_on);
    chk("tx_cmd_b", tx_cb, 1'b0);
  endtask : settle
  // Heartbeat edges over two half periods; a stopped wave shows none
  task automatic beats(int exp);
    logic prev;
    int n;
    n = 0;
    for (int i = 0; i < 2 * BEAT; i++)
    begin
      prev = beat;
      tick(1);
      n += (beat !== prev);
    end
    chk("beat_edges", n == exp, 1'b1);
  endtask : beats
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_idle();
    chk("cfg_a_n", cfg_a_n, 1'b0);
    chk("cfg_b_n", cfg_b_n, 1'b0);
    chk("b_sel_n", bsel_n, 1'b0);
    chk("manual", manual, 1'b0);
    chk("sw_fault", sw_flt, 1'b0);
    beats(2);
    mc_rx = 1'b0;
    mc_tb = 1'b0;
    tick(2);
    chk("mc_rx_a", mc_ra, 1'b0);
    chk("mc_rx_b", mc_rb, 1'b0);
    chk("mc_tx", mc_tx, 1'b0);
    mc_rx = 1'b1;
    mc_tb = 1'b1;
    tick(2);
    chk("mc_tx", mc_tx, 1'b1);
  endtask : t_idle
  task automatic t_auto();
    flt_a = 1'b1;
    settle(1'b1);
    tick(10);
    flt_b = 1'b1;
    settle(1'b1);
    flt_b = 1'b0;
    rtoggle();
    settle(1'b1);
    flt_a = 1'b0;
    tick(10);
    rtoggle();
    settle(1'b0);
  endtask : t_auto
  task automatic t_pin();
    tog_req = 1'b0;
    tick(6);
    tog_req = 1'b1;
    settle(1'b0);
    tog_req = 1'b0;
    tick(30);
    tog_req = 1'b1;
    settle(1'b1);
  endtask : t_pin
  task automatic t_manual();
    mode_sel = 1'b0;
    tick(12);
    rmode(1'b0);
    chk("manual", manual, 1'b1);
    flt_a = 1'b1;
    rtoggle();
    settle(1'b0);
    rtoggle();
    tick(5);
    rtoggle();
    settle(1'b1);
    flt_a = 1'b0;
    mode_sel = 1'b1;
    tick(12);
    rmode(1'b1);
    chk("manual", manual, 1'b1);
    rmode(1'b0);
    chk("manual", manual, 1'b0);
  endtask : t_manual
  // A jammed Rx switch must stop the heartbeat until the pair agrees again
  task automatic t_stuck();
    rx_stuck = 1'b1;
    rtoggle();
    settle(1'b0);
    chk("sw_fault", sw_flt, 1'b1);
    chk("beat", beat, 1'b0);
    beats(0);
    rx_stuck = 1'b0;
    rtoggle();
    settle(1'b1);
    chk("sw_fault", sw_flt, 1'b0);
    beats(2);
  endtask : t_stuck
  task automatic t_reset();
    rtoggle();
    tick(5);
    rst = 1'b1;
    tick(16);
    chk("tx_cmd_a", tx_ca, 1'b0);
    rst = 1'b0;
    settle(1'b0);
  endtask : t_reset
  // ------------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    tick(16);
    rst = 1'b0;
    tick(20);
    t_idle();
    t_auto();
    t_pin();
    t_manual();
    t_stuck();
    t_reset();
    summarize();
  end
endmodule : rsc_core_bench
